/* rtl/brake_stop_sequencer.v */
// Operation
// - stop mode picks ramp down or coast
// - brake high without ack trips fault
// - ack still on after engage warns
// - brake lifts when release time expires
// - release speed and torque during release, 90% if release torque zero
// - release speed clamped below 32767
// - hold load for engage time after brake
// - wait time keeps brake open, restart allowed
// - torque before release, brake before removal
// - vector brake selects braking current limit
// - release torque floor, raised by measured
// - zero release torque selects 90% default; sign direction
// - release torque beats speed-derived init
// - ack input and brake output pins
// - dc hold enable, speed mode only
// - dc hold below threshold speed, ref
// - dc hold current percent of nominal
// - start vector fixed, stepping or encoder
`timescale 1ns/1ps
`default_nettype none
`include "brake_stop_map.vh"
module brake_stop_sequencer #(
  parameter TICK_CYCLES = `TICK_CYCLES
) (
  // clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // motor control side
  input  wire        run_cmd,
  input  wire [15:0] speed_act,
  input  wire [15:0] speed_ref,
  input  wire [15:0] torque_act,
  input  wire [2:0]  enc_vector,
  output reg         ramp_en,
  output reg         coast,
  output reg         hold_torque,
  output reg  [15:0] speed_init,
  output reg  [15:0] torque_init,
  output reg         vec_brake,
  output reg         dc_clamp_on,
  output reg  [6:0]  dc_clamp_current_level,
  output reg  [2:0]  start_vector,
  // brake pins
  input  wire        brake_ack_pin,
  output reg         brake_out,
  output reg         brake_trip,
  output reg         brake_warn
);
  // =====================================
  // states
  localparam [2:0] S_IDLE = 3'd0;
  localparam [2:0] S_REL  = 3'd1;
  localparam [2:0] S_RUN  = 3'd2;
  localparam [2:0] S_STOP = 3'd3;
  localparam [2:0] S_WAIT = 3'd4;
  localparam [2:0] S_ENG  = 3'd5;
  localparam [2:0] S_HOLD = 3'd6;

  // =====================================
  // helpers
  function [15:0] abs16;
    input [15:0] v;
    begin
      abs16 = v[15] ? (~v + 16'h0001) : v;
    end
  endfunction

  function [11:0] lim12;
    input [11:0] v;
    input [11:0] m;
    begin
      lim12 = (v > m) ? m : v;
    end
  endfunction

  function [15:0] clamp_trq;
    input [15:0] v;
    begin
      if (!v[15] && v > `LIM_TRQ)
        clamp_trq = `LIM_TRQ;
      else if (v[15] && abs16(v) > `LIM_TRQ)
        clamp_trq = ~`LIM_TRQ + 16'h0001;
      else
        clamp_trq = v;
    end
  endfunction

  // =====================================
  // registers
  reg [6:0]  ctrl_r;
  reg [11:0] rel_t_r;
  reg [11:0] eng_t_r;
  reg [11:0] wait_t_r;
  reg [11:0] flt_t_r;
  reg [15:0] rel_spd_r;
  reg [15:0] rel_trq_r;
  reg [7:0]  dc_thr_r;
  reg [6:0]  dc_cur_r;
  reg [15:0] meas_trq_r;
  reg [2:0]  state_r;
  reg [2:0]  state_nxt;
  reg [31:0] pre_r;
  reg [11:0] tmr_r;
  reg [11:0] flt_cnt_r;
  reg [2:0]  seq_r;
  reg        ack_s1_r;
  reg        ack_r;

  wire tick = (pre_r == TICK_CYCLES - 1);
  wire tmr_done = (tmr_r == 12'h000);
  wire wr_en = psel & penable & pready & pwrite;
  wire stop_coast = ctrl_r[`CTRL_STOP_MODE];
  wire brk_en = ctrl_r[`CTRL_BRAKE_EN];
  wire at_zero = (abs16(speed_act) == 16'h0000);
  wire clr_trip = wr_en && paddr == `OFS_STATUS
                  && pwdata[`ST_TRIP];
  wire clr_warn = wr_en && paddr == `OFS_STATUS
                  && pwdata[`ST_WARN];

  // =====================================
  // brake ack synchroniser
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_s1_r <= 1'b0;
      ack_r    <= 1'b0;
    end else begin
      ack_s1_r <= brake_ack_pin;
      ack_r    <= ack_s1_r;
    end
  end

  // =====================================
  // apb slave, zero wait
  reg        map_hit;
  reg [31:0] rd_val;
  always @* begin
    map_hit = 1'b1;
    rd_val  = 32'h0000_0000;
    case (paddr)
      `OFS_CTRL:      rd_val = {25'h0, ctrl_r};
      `OFS_REL_TIME:  rd_val = {20'h0, rel_t_r};
      `OFS_ENG_TIME:  rd_val = {20'h0, eng_t_r};
      `OFS_WAIT_TIME: rd_val = {20'h0, wait_t_r};
      `OFS_FLT_TIME:  rd_val = {20'h0, flt_t_r};
      `OFS_REL_SPD:   rd_val = {16'h0, rel_spd_r};
      `OFS_REL_TRQ:   rd_val = {16'h0, rel_trq_r};
      `OFS_DC_HOLD:   rd_val = {17'h0, dc_cur_r, dc_thr_r};
      `OFS_STATUS:    rd_val = {25'h0, state_r, ack_r,
                                brake_out, brake_warn,
                                brake_trip};
      `OFS_MEAS_TRQ:  rd_val = {16'h0, meas_trq_r};
      default:        map_hit = 1'b0;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~map_hit;
      if (psel && !penable)
        prdata <= pwrite ? 32'h0000_0000 : rd_val;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r    <= `RST_CTRL;
      rel_t_r   <= `RST_REL_TIME;
      eng_t_r   <= `RST_ENG_TIME;
      wait_t_r  <= `RST_WAIT_TIME;
      flt_t_r   <= `RST_FLT_TIME;
      rel_spd_r <= `RST_REL_SPD;
      rel_trq_r <= `RST_REL_TRQ;
      dc_thr_r  <= `RST_DC_THR;
      dc_cur_r  <= `RST_DC_CUR;
    end else if (wr_en) begin
      case (paddr)
        `OFS_CTRL:
          ctrl_r <= pwdata[6:0];
        `OFS_REL_TIME:
          rel_t_r <= lim12(pwdata[11:0], `LIM_REL_TIME);
        `OFS_ENG_TIME:
          eng_t_r <= lim12(pwdata[11:0], `LIM_REL_TIME);
        `OFS_WAIT_TIME:
          wait_t_r <= lim12(pwdata[11:0], `LIM_WAIT_TIME);
        `OFS_FLT_TIME:
          flt_t_r <= lim12(pwdata[11:0], `LIM_FLT_TIME);
        `OFS_REL_SPD: begin
          if (pwdata[15:0] > `SPD_CLAMP && !pwdata[15])
            rel_spd_r <= `SPD_CLAMP;
          else
            rel_spd_r <= pwdata[15:0];
        end
        `OFS_REL_TRQ:
          rel_trq_r <= clamp_trq(pwdata[15:0]);
        `OFS_DC_HOLD: begin
          dc_thr_r <= (pwdata[7:0] > `LIM_DC_THR)
                      ? `LIM_DC_THR : pwdata[7:0];
          dc_cur_r <= (pwdata[14:8] > `LIM_DC_CUR)
                      ? `LIM_DC_CUR : pwdata[14:8];
        end
        default: ;
      endcase
    end
  end

  // =====================================
  // sequencer
  always @* begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE:
        if (run_cmd && !brake_trip)
          state_nxt = brk_en ? S_REL : S_RUN;
      S_REL:
        if (!run_cmd)
          state_nxt = S_IDLE;
        else if (tmr_done)
          state_nxt = S_RUN;
      S_RUN:
        if (!run_cmd)
          state_nxt = S_STOP;
      S_STOP:
        if (run_cmd)
          state_nxt = S_RUN;
        else if (at_zero)
          state_nxt = brk_en ? S_WAIT : S_IDLE;
      S_WAIT:
        if (run_cmd)
          state_nxt = S_RUN;
        else if (tmr_done)
          state_nxt = S_ENG;
      S_ENG:
        if (tmr_done)
          state_nxt = ack_r ? S_HOLD : S_IDLE;
      S_HOLD:
        if (!ack_r)
          state_nxt = S_IDLE;
      default:
        state_nxt = S_IDLE;
    endcase
    if (brake_trip && state_r != S_IDLE)
      state_nxt = S_IDLE;
  end

  // release torque choice, measured floor
  reg [15:0] trq_sel;
  always @* begin
    trq_sel = `TRQ_HOLD_PCT;
    if (rel_trq_r != 16'h0000) begin
      if (abs16(meas_trq_r) > abs16(rel_trq_r))
        trq_sel = rel_trq_r[15]
                  ? ~abs16(meas_trq_r) + 16'h0001
                  : abs16(meas_trq_r);
      else
        trq_sel = rel_trq_r;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r    <= S_IDLE;
      pre_r      <= 32'h0000_0000;
      tmr_r      <= 12'h000;
      meas_trq_r <= 16'h0000;
      seq_r      <= 3'h0;
    end else begin
      state_r <= state_nxt;
      pre_r   <= tick ? 32'h0000_0000 : pre_r + 32'h1;
      if (state_nxt != state_r) begin
        case (state_nxt)
          S_REL:   tmr_r <= rel_t_r;
          S_WAIT:  tmr_r <= wait_t_r;
          S_ENG:   tmr_r <= eng_t_r;
          default: tmr_r <= 12'h000;
        endcase
      end else if (tick && !tmr_done)
        tmr_r <= tmr_r - 12'h001;
      if (state_r == S_WAIT && state_nxt == S_ENG)
        meas_trq_r <= torque_act;
      if (state_r == S_IDLE && state_nxt != S_IDLE)
        seq_r <= (seq_r == 3'h5) ? 3'h0 : seq_r + 3'h1;
    end
  end

  // =====================================
  // brake supervision
  wire brk_open = (state_r == S_RUN) || (state_r == S_STOP)
                  || (state_r == S_WAIT);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flt_cnt_r  <= 12'h000;
      brake_trip <= 1'b0;
      brake_warn <= 1'b0;
    end else begin
      if (brake_out && !ack_r) begin
        if (tick && flt_cnt_r != flt_t_r)
          flt_cnt_r <= flt_cnt_r + 12'h001;
      end else
        flt_cnt_r <= 12'h000;
      if (brake_out && !ack_r && flt_cnt_r == flt_t_r)
        brake_trip <= 1'b1;
      else if (clr_trip)
        brake_trip <= 1'b0;
      if (state_r == S_ENG && tmr_done && ack_r)
        brake_warn <= 1'b1;
      else if (clr_warn)
        brake_warn <= 1'b0;
    end
  end

  // =====================================
  // outputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brake_out   <= 1'b0;
      ramp_en     <= 1'b0;
      coast       <= 1'b0;
      hold_torque <= 1'b0;
      speed_init  <= 16'h0000;
      torque_init <= 16'h0000;
      vec_brake   <= 1'b0;
      dc_clamp_on <= 1'b0;
      dc_clamp_current_level <= 7'h00;
      start_vector <= 3'h0;
    end else begin
      brake_out <= brk_en && !brake_trip
                   && (state_nxt == S_RUN || brk_open
                       && state_nxt == S_WAIT
                       || state_nxt == S_STOP);
      ramp_en <= (state_nxt == S_RUN);
      coast   <= brake_trip || (state_nxt == S_STOP
                 && stop_coast);
      hold_torque <= (state_nxt == S_REL)
                     || (state_nxt == S_WAIT)
                     || (state_nxt == S_ENG)
                     || (state_nxt == S_HOLD);
      speed_init  <= (state_nxt == S_REL)
                     ? rel_spd_r : 16'h0000;
      torque_init <= (state_nxt == S_REL)
                     ? trq_sel : 16'h0000;
      vec_brake   <= ctrl_r[`CTRL_VEC_BRAKE];
      dc_clamp_on <= ctrl_r[`CTRL_DC_EN]
                     && ctrl_r[`CTRL_SPD_MODE]
                     && abs16(speed_act) < {8'h00, dc_thr_r}
                     && abs16(speed_ref) < {8'h00, dc_thr_r};
      dc_clamp_current_level <= dc_cur_r;
      if (state_r == S_IDLE && state_nxt != S_IDLE) begin
        case (ctrl_r[`CTRL_SV_HI:`CTRL_SV_LO])
          2'd1:    start_vector <= seq_r;
          2'd2:    start_vector <= enc_vector;
          default: start_vector <= 3'h0;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

/* rtl/brake_stop_map.vh */
`ifndef BRAKE_STOP_MAP_VH
`define BRAKE_STOP_MAP_VH
// =====================================
// register offsets
`define OFS_CTRL      8'h00
`define OFS_REL_TIME  8'h04
`define OFS_ENG_TIME  8'h08
`define OFS_WAIT_TIME 8'h0C
`define OFS_FLT_TIME  8'h10
`define OFS_REL_SPD   8'h14
`define OFS_REL_TRQ   8'h18
`define OFS_DC_HOLD   8'h1C
`define OFS_STATUS    8'h20
`define OFS_MEAS_TRQ  8'h24
// =====================================
// ctrl fields
`define CTRL_STOP_MODE  0
`define CTRL_VEC_BRAKE  1
`define CTRL_BRAKE_EN   2
`define CTRL_DC_EN      3
`define CTRL_SPD_MODE   4
`define CTRL_SV_LO      5
`define CTRL_SV_HI      6
// status fields
`define ST_TRIP         0
`define ST_WARN         1
`define ST_BRAKE        2
`define ST_ACK          3
`define ST_STATE_LO     4
`define ST_STATE_HI     6
// dc hold fields
`define DC_THR_LO       0
`define DC_THR_HI       7
`define DC_CUR_LO       8
`define DC_CUR_HI       14
// =====================================
// reset values, times in 10 ms units
`define RST_CTRL      7'h14
`define RST_REL_TIME  12'h000
`define RST_ENG_TIME  12'h000
`define RST_WAIT_TIME 12'h000
`define RST_FLT_TIME  12'h064
`define RST_REL_SPD   16'h0000
`define RST_REL_TRQ   16'h0000
`define RST_DC_THR    8'h0A
`define RST_DC_CUR    7'h1E
// =====================================
// limits and timing
`define LIM_REL_TIME  12'h12C
`define LIM_WAIT_TIME 12'hBB8
`define LIM_FLT_TIME  12'h1F4
`define LIM_TRQ       16'h0190
`define LIM_DC_THR    8'hFA
`define LIM_DC_CUR    7'h64
`define SPD_CLAMP     16'h7FFE
`define TRQ_HOLD_PCT  16'h005A
`define TIME_UNIT_NS  10000000
`define CLK_NS        10
`define TICK_CYCLES   (`TIME_UNIT_NS / `CLK_NS)
`endif

/* tb/brake_stop_props.sv */
`timescale 1ns/1ps
`default_nettype none
`include "brake_stop_map.vh"
module brake_stop_props (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // register bus
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  // motor and brake
  input wire logic [15:0] speed_act,
  input wire logic        brake_ack_pin,
  input wire logic        ramp_en,
  input wire logic        coast,
  input wire logic        hold_torque,
  input wire logic        vec_brake,
  input wire logic        dc_clamp_on,
  input wire logic        brake_out,
  input wire logic        brake_trip,
  input wire logic        brake_warn
);
  // ==========
  // sequences
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence ctrl_write;
    psel && penable && pready && pwrite && paddr == `OFS_CTRL;
  endsequence
  sequence brake_lift;
    !brake_out ##1 brake_out;
  endsequence
  sequence fast_spin;
    !speed_act[15] && speed_act > 16'h00FA;
  endsequence
  // ==========
  // properties
  chk_vec_brake_bit: assert property (ctrl_write |-> ##2 vec_brake == $past(pwdata[1], 2))
    else $error("vector brake not following control");
  chk_torque_before_lift: assert property (brake_lift |-> $past(hold_torque))
    else $error("brake lifted without holding torque");
  chk_brake_before_drop: assert property ($fell(hold_torque) && !ramp_en |-> !brake_out)
    else $error("torque removed with brake open");
  chk_ramp_after_lift: assert property ($rose(ramp_en) |-> brake_out)
    else $error("ramp started before brake lift");
  chk_trip_cause: assert property ($rose(brake_trip) |->
    $past(brake_out) && !$past(brake_ack_pin, 3))
    else $error("trip without missing acknowledge");
  chk_trip_coasts: assert property ($rose(brake_trip) |-> ##[0:2] (coast && !brake_out))
    else $error("trip did not drop brake and drive");
  chk_warn_keeps_torque: assert property ($rose(brake_warn) |-> !brake_out && hold_torque)
    else $error("warning without held torque");
  chk_dc_off_fast: assert property (fast_spin [*3] |-> !dc_clamp_on)
    else $error("dc hold on above threshold");
endmodule
bind brake_stop_sequencer brake_stop_props brake_stop_props_inst (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .speed_act,
  .brake_ack_pin, .ramp_en, .coast, .hold_torque, .vec_brake, .dc_clamp_on, .brake_out,
  .brake_trip, .brake_warn);
`default_nettype wire

/* tb/brake_model.sv */
`timescale 1ns/1ps
`default_nettype none
module brake_model (
  // coil and contact
  input  wire logic       pclk,
  input  wire logic       brake_out,
  input  wire logic [1:0] fail_mode,
  output var  logic       brake_ack_pin
);
  logic dly_r = 1'b0;
  // contact trails the coil; 1 never opens, 2 never closes
  always @(posedge pclk) begin
    dly_r <= brake_out;
    brake_ack_pin <= fail_mode[0] ? 1'b0 : (fail_mode[1] | dly_r);
  end
endmodule
`default_nettype wire

/* tb/brake_stop_sequencer_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "brake_stop_map.vh"
module brake_stop_sequencer_tb_top;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        run_cmd = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [15:0] speed_act = 16'h0000;
  logic [15:0] speed_ref = 16'h0000;
  logic [15:0] torque_act = 16'h0000;
  logic [2:0]  enc_vector = 3'h0;
  logic [1:0]  fail_mode = 2'h0;
  logic [15:0] spd = 16'h0000;
  wire  [31:0] prdata;
  wire         pready, pslverr, ramp_en, coast, hold_torque, vec_brake;
  wire         dc_clamp_on, brake_out, brake_trip, brake_warn, brake_ack_pin;
  wire  [15:0] speed_init, torque_init;
  wire  [6:0]  dc_clamp_current_level;
  wire  [2:0]  start_vector;
  wire  [5:0]  mon = {ramp_en, coast, brake_warn, brake_trip, hold_torque, brake_out};
  int          failures = 0;
  int          checks_done = 0;
  int          n;
  int          m;
  logic [32:0] exp_q[$];
  logic [7:0]  ta [6] = '{`OFS_REL_TIME, `OFS_ENG_TIME, `OFS_WAIT_TIME, `OFS_FLT_TIME,
                          `OFS_REL_SPD, `OFS_REL_TRQ};
  logic [31:0] tr [6] = '{32'h0, 32'h0, 32'h0, 32'h64, 32'h0, 32'h0};
  logic [31:0] tw [6] = '{32'hFFF, 32'hFFF, 32'hFFF, 32'hFFF, 32'h7FFF, 32'h1F4};
  logic [31:0] tc [6] = '{32'h12C, 32'h12C, 32'hBB8, 32'h1F4, 32'h7FFE, 32'h190};
  brake_stop_sequencer #(.TICK_CYCLES(4)) brake_stop_sequencer_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .run_cmd, .speed_act, .speed_ref, .torque_act, .enc_vector, .ramp_en,
    .coast, .hold_torque, .speed_init, .torque_init, .vec_brake, .dc_clamp_on,
    .dc_clamp_current_level, .start_vector, .brake_ack_pin, .brake_out, .brake_trip,
    .brake_warn);
  brake_model brake_model_inst (.pclk, .brake_out, .fail_mode, .brake_ack_pin);
  // ==========
  // helpers
  initial forever #5 pclk = ~pclk;
  task automatic chk(input logic [32:0] g, input logic [32:0] e);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic final_report();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     input logic [32:0] e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) exp_q.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (!pready);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_bit(input int i, input logic v, output int k);
    k = 0;
    while (mon[i] !== v && k < 400) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 400) begin
      failures++;
      $display("CHECK FAILED %0t wait for output %0d timed out", $time, i);
    end
  endtask
  task automatic run_stop(input logic [15:0] trq, input logic stuck);
    run_cmd <= 1'b1;
    wait_bit(1, 1'b1, n);
    repeat (2) @(posedge pclk);
    chk(speed_init, spd);
    chk(torque_init, trq);
    wait_bit(0, 1'b1, m);
    chk(33'(n + m >= 10 && n + m <= 15), 1);
    repeat (2) @(posedge pclk);
    chk(ramp_en, 1);
    if (stuck) fail_mode <= 2'h2;
    run_cmd <= 1'b0;
    wait_bit(0, 1'b0, n);
    chk(33'(n >= 8 && n <= 13), 1);
    chk(hold_torque, 1);
    wait_bit(stuck ? 3 : 1, stuck, n);
    chk(33'(n >= 6 && n <= 9), 1);
    if (stuck) begin
      chk(hold_torque, 1);
      fail_mode <= 2'h0;
      wait_bit(1, 1'b0, n);
      chk(33'(n < 12), 1);
      apb(`OFS_STATUS, 1, 32'h2, 0);
      @(posedge pclk);
      chk(brake_warn, 0);
    end
  endtask
  // ==========
  // read data checker
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      chk({pslverr, prdata}, exp_q.pop_front());
    end
  end
  initial begin
    #300us;
    failures++;
    final_report();
  end
  // ==========
  // tests
  initial begin
    void'($urandom(32'h309E3963));
    enc_vector <= 3'($urandom_range(5, 0));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(`OFS_CTRL, 0, 0, 33'h14);
    apb(`OFS_DC_HOLD, 0, 0, 33'h1E0A);
    apb(8'h30, 1, 32'h5, 0);
    apb(8'h30, 0, 0, 33'h100000000);
    for (int i = 0; i < 6; i++) begin
      apb(ta[i], 0, 0, {1'b0, tr[i]});
      apb(ta[i], 1, tw[i], 0);
      apb(ta[i], 0, 0, {1'b0, tc[i]});
    end
    apb(`OFS_DC_HOLD, 1, 32'hFFFF, 0);
    apb(`OFS_DC_HOLD, 0, 0, 33'h64FA);
    for (int i = 0; i < 4; i++) begin
      apb(`OFS_CTRL, 1, 32'h14 | 32'(i), 0);
      repeat (3) @(posedge pclk);
      chk(vec_brake, i[1]);
    end
    apb(`OFS_CTRL, 1, 32'h14, 0);
    apb(`OFS_REL_TIME, 1, 32'h3, 0);
    apb(`OFS_ENG_TIME, 1, 32'h2, 0);
    apb(`OFS_WAIT_TIME, 1, 32'h2, 0);
    apb(`OFS_FLT_TIME, 1, 32'h64, 0);
    apb(`OFS_REL_TRQ, 1, 32'h0, 0);
    spd = 16'($urandom_range(32766, 1));
    apb(`OFS_REL_SPD, 1, {16'h0, spd}, 0);
    torque_act <= 16'h0014;
    run_stop(16'h005A, 0);
    apb(`OFS_REL_TRQ, 1, 32'hFFCE, 0);
    run_stop(16'hFFCE, 0);
    apb(`OFS_REL_TRQ, 1, 32'hFFF6, 0);
    run_stop(16'hFFEC, 1);
    // acknowledge never arrives
    apb(`OFS_FLT_TIME, 1, 32'h5, 0);
    fail_mode <= 2'h1;
    run_cmd <= 1'b1;
    wait_bit(0, 1'b1, n);
    wait_bit(2, 1'b1, n);
    chk(33'(n >= 18 && n <= 26), 1);
    repeat (3) @(posedge pclk);
    chk({brake_out, coast}, 2'b01);
    run_cmd <= 1'b0;
    fail_mode <= 2'h0;
    apb(`OFS_STATUS, 1, 32'h1, 0);
    @(posedge pclk);
    chk(brake_trip, 0);
    // coasting stop
    apb(`OFS_CTRL, 1, 32'h15, 0);
    run_cmd <= 1'b1;
    wait_bit(0, 1'b1, n);
    run_cmd <= 1'b0;
    wait_bit(4, 1'b1, n);
    chk(33'(n <= 4), 1);
    wait_bit(0, 1'b0, n);
    wait_bit(1, 1'b0, n);
    // dc hold
    apb(`OFS_DC_HOLD, 1, 32'h1E0A, 0);
    for (int i = 0; i < 4; i++) begin
      apb(`OFS_CTRL, 1, (i == 3) ? 32'h0C : 32'h1C, 0);
      speed_act <= (i == 2) ? 16'h012C : 16'h0005;
      speed_ref <= (i == 1) ? 16'h000A : 16'h0005;
      repeat (4) @(posedge pclk);
      chk(dc_clamp_on, 33'(i == 0));
      if (i == 0) chk(dc_clamp_current_level, 33'h1E);
    end
    // start vector: encoder, two stepping starts, fixed
    for (int i = 0; i < 4; i++) begin
      apb(`OFS_CTRL, 1, (i == 0) ? 32'h54 : (i == 3) ? 32'h14 : 32'h34, 0);
      run_cmd <= 1'b1;
      wait_bit(1, 1'b1, n);
      if (i == 0) chk(start_vector, 33'(enc_vector));
      if (i == 2) chk(start_vector, (m == 5) ? 33'h0 : 33'(m + 1));
      if (i == 3) chk(start_vector, 0);
      m = start_vector;
      run_cmd <= 1'b0;
      wait_bit(1, 1'b0, n);
    end
    final_report();
  end
endmodule
`default_nettype wire
